/* File: logic/upfc_defines.vh */
// constants for the usb port fault, thermal and mode control block
// assumes a 100 MHz core clock and strap codes already digitised
`ifndef UPFC_DEFINES_VH
`define UPFC_DEFINES_VH

// ****************************************
// timing
// ****************************************
`define UPFC_CLK_MHZ        100
`define UPFC_STB_MS         2000
`define UPFC_STB_CYC        (`UPFC_STB_MS * 100000)
`define UPFC_RETRY_US       1000
`define UPFC_RETRY_CYC      (`UPFC_RETRY_US * `UPFC_CLK_MHZ)

// ****************************************
// temperatures in whole degrees c
// ****************************************
`define UPFC_TSD_TRIP       8'd165
`define UPFC_TSD_HYST       8'd10
`define UPFC_TWARN_TRIP     8'd140

// ****************************************
// register offsets
// ****************************************
`define UPFC_A_SETUP1       4'h0
`define UPFC_A_SETUP2       4'h1
`define UPFC_A_ADVERT       4'h2
`define UPFC_A_IRQ1         4'h3
`define UPFC_A_IRQ2         4'h4
`define UPFC_A_MASK1        4'h5
`define UPFC_A_MASK2        4'h6
`define UPFC_A_STATUS       4'h7

// ****************************************
// field positions and reset values
// ****************************************
`define UPFC_IRQ1_UV        0
`define UPFC_IRQ1_STB       1
`define UPFC_IRQ2_WARN      0
`define UPFC_IRQ2_TSD       1
`define UPFC_SETUP2_FLDBK   3
`define UPFC_RST_SETUP1     8'h00
`define UPFC_RST_SETUP2     8'h0B
`define UPFC_RST_ADVERT     8'h01

// ****************************************
// data switch modes
// ****************************************
`define UPFC_MODE_OFF       2'h0
`define UPFC_MODE_SDP       2'h1
`define UPFC_MODE_CDP       2'h2
`define UPFC_MODE_BAD       2'h3

`endif

/* File: logic/upfc_timer.v */
// down counter that reports when a loaded delay has elapsed
// assumes load and run come from logic on the same clock
`timescale 1ns/1ps
`include "upfc_defines.vh"

module upfc_timer #(
  parameter WIDTH = 28
) (
  input  wire             i_core_clk,
  input  wire             i_rst_n,
  input  wire             i_ce,
  input  wire             i_load,
  input  wire [WIDTH-1:0] i_count,
  output reg              o_done
);
  reg [WIDTH-1:0] count;

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count  <= {WIDTH{1'b0}};
      o_done <= 1'b1;
    end else if (i_ce) begin
      if (i_load) begin
        count  <= i_count;
        o_done <= 1'b0;
      end else if (count != {WIDTH{1'b0}}) begin
        count  <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      end else begin
        o_done <= 1'b1;
      end
    end
  end
endmodule

/* File: logic/upfc_sync.v */
// two flip-flop synchroniser for a bus of pin levels
// assumes the inputs are quasi-static or bit independent
`timescale 1ns/1ps

module upfc_sync #(
  parameter WIDTH = 8
) (
  input  wire             i_core_clk,
  input  wire             i_rst_n,
  input  wire             i_ce,
  input  wire [WIDTH-1:0] i_async,
  output reg  [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta;

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta   <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end else if (i_ce) begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule

/* File: logic/upfc_ctrl.v */
// usb port protection, thermal and data switch mode control
// assumes analog comparators and strap decoders deliver pin levels
//
// Overview of operation
// - a short to ground or undervoltage resets the converter, raises fault and irq1, then retries after the reset delay.
// - a short to battery shuts the converter, opens the bus gate, raises fault, and raises irq1 only if it starts in the run state.
// - after a short to battery the converter stays off until the fault clears and 2 s pass.
// - above 165 c the device shuts down.
// - it restarts only after cooling 10 c below the trip.
// - crossing 140 c sets the overtemp warning flag in irq2.
// - with foldback on and the warning set the advert drops one step.
// - below the warning threshold the advert returns to the programmed value.
// - foldback touches only the advert, never the bus, mode or current limit.
// - a 3-bit field of setup two picks one of eight current limits.
// - strap variants take the limit from a subset set by strap pin three.
// - a 5-bit field of setup one sets the cable compensation gain.
// - strap variants take gain low bits from strap two and the msb from strap three.
// - enabled without logic supply the data switch mode is invalid.
// - both pass-through sdp and charging downstream cdp modes exist.
// - with charge mode select low and detect select 00 the port starts in pass-through sdp.
`timescale 1ns/1ps
`include "upfc_defines.vh"

module upfc_ctrl #(
  parameter STB_CYCLES   = `UPFC_STB_CYC,
  parameter RETRY_CYCLES = `UPFC_RETRY_CYC,
  parameter STRAP_MODE   = 0
) (
  input  wire       i_core_clk,
  input  wire       i_rst_n,
  input  wire       i_ce,
  input  wire [3:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  input  wire       i_short_gnd,
  input  wire       i_undervolt,
  input  wire       i_sense_neg_ov,
  input  wire [7:0] i_die_temp,
  input  wire [3:0] i_strap_pin_two,
  input  wire [3:0] i_strap_pin_three,
  input  wire       i_high_voltage_enable,
  input  wire       i_logic_supply_sense,
  input  wire       i_charge_mode_select,
  input  wire [1:0] i_charge_detect_select,
  input  wire       i_cdp_status,
  output reg        o_converter_en,
  output reg        o_bus_output_gate,
  output reg        o_fault,
  output reg        o_irq,
  output reg  [1:0] o_source_current,
  output reg  [2:0] o_load_current_limit_sel,
  output reg  [4:0] o_cable_gain,
  output reg        o_data_switch_a,
  output reg        o_data_switch_b,
  output reg  [1:0] o_switch_mode
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  wire [7:0]  temp_s;
  wire [3:0]  s2_s;
  wire [3:0]  s3_s;
  wire [8:0]  pin_s;

  upfc_sync #(.WIDTH(8)) u_sync_temp (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .i_async    (i_die_temp),
    .o_sync     (temp_s)
  );

  upfc_sync #(.WIDTH(17)) u_sync_pins (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .i_async    ({i_strap_pin_two, i_strap_pin_three, i_short_gnd,
                  i_undervolt, i_sense_neg_ov, i_high_voltage_enable,
                  i_logic_supply_sense, i_charge_mode_select,
                  i_charge_detect_select, i_cdp_status}),
    .o_sync     ({s2_s, s3_s, pin_s})
  );

  wire       short_s = pin_s[8] | pin_s[7];
  wire       ov_s    = pin_s[6];
  wire       high_voltage_enable_s  = pin_s[5];
  wire       supp_s  = pin_s[4];
  wire       cms_s   = pin_s[3];
  wire [1:0] cds_s   = pin_s[2:1];
  wire       cdp_s   = pin_s[0];

  // ****************************************
  // registers
  // ****************************************
  reg [7:0] setup1;
  reg [7:0] setup2;
  reg [7:0] advert;
  reg [1:0] irq1;
  reg [1:0] irq2;
  reg [1:0] mask1;
  reg [1:0] mask2;
  reg       thermal_off;
  reg       warn_lvl;
  reg [1:0] strap_cnt;

  // ****************************************
  // fault state machine
  // ****************************************
  localparam ST_RUN   = 2'd0;
  localparam ST_RESET = 2'd1;
  localparam ST_STB   = 2'd2;

  reg  [1:0] state;
  reg  [1:0] next_state;
  reg        tmr_load;
  reg [27:0] tmr_count;
  wire       tmr_done;

  upfc_timer #(.WIDTH(28)) u_timer (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .i_load     (tmr_load),
    .i_count    (tmr_count),
    .o_done     (tmr_done)
  );

  always @* begin
    next_state = state;
    tmr_load   = 1'b0;
    tmr_count  = RETRY_CYCLES[27:0];
    case (state)
      ST_RUN: begin
        if (ov_s) begin
          next_state = ST_STB;
          tmr_load   = 1'b1;
          tmr_count  = STB_CYCLES[27:0];
        end else if (short_s) begin
          next_state = ST_RESET;
          tmr_load   = 1'b1;
        end
      end
      ST_RESET: begin
        if (ov_s) begin
          next_state = ST_STB;
          tmr_load   = 1'b1;
          tmr_count  = STB_CYCLES[27:0];
        end else if (tmr_done && !tmr_load) begin
          next_state = ST_RUN;
        end
      end
      ST_STB: begin
        // the 2 s window restarts while the short persists
        if (ov_s) begin
          tmr_load  = 1'b1;
          tmr_count = STB_CYCLES[27:0];
        end else if (tmr_done) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_RUN;
    end else if (i_ce) begin
      state <= next_state;
    end
  end

  // ****************************************
  // thermal
  // ****************************************
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      thermal_off <= 1'b0;
      warn_lvl    <= 1'b0;
    end else if (i_ce) begin
      if (temp_s > `UPFC_TSD_TRIP) begin
        thermal_off <= 1'b1;
      end else if (temp_s <= `UPFC_TSD_TRIP - `UPFC_TSD_HYST) begin
        thermal_off <= 1'b0;
      end
      warn_lvl <= (temp_s > `UPFC_TWARN_TRIP);
    end
  end

  // one step down, lowest setting stays put
  function [1:0] upfc_fold;
    input [1:0] lvl;
    begin
      upfc_fold = (lvl == 2'd0) ? 2'd0 : lvl - 2'd1;
    end
  endfunction

  // ****************************************
  // register bus and interrupt flags
  // ****************************************
  wire       wr_irq1 = i_wr && (i_addr == `UPFC_A_IRQ1);
  wire       wr_irq2 = i_wr && (i_addr == `UPFC_A_IRQ2);
  wire [1:0] ev1     = {(state == ST_RUN) & ov_s,
                        (state == ST_RUN) & short_s & ~ov_s};
  wire       warn_rise = (temp_s > `UPFC_TWARN_TRIP) & ~warn_lvl;
  wire       tsd_rise  = (temp_s > `UPFC_TSD_TRIP) & ~thermal_off;
  wire [1:0] ev2     = {tsd_rise, warn_rise};

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      setup1     <= `UPFC_RST_SETUP1;
      setup2     <= `UPFC_RST_SETUP2;
      advert     <= `UPFC_RST_ADVERT;
      irq1       <= 2'h0;
      irq2       <= 2'h0;
      mask1      <= 2'h0;
      mask2      <= 2'h0;
      strap_cnt  <= 2'd0;
      o_rdata    <= 8'h00;
    end else if (i_ce) begin
      // straps are caught once, after the syncs hold real pin levels
      if (strap_cnt == 2'd2 && STRAP_MODE != 0) begin
        setup1[3:0] <= s2_s;
        setup1[4]   <= s3_s[2];
        setup2[2:0] <= {s3_s[1:0] == 2'd0 ? 3'd0 :
                        s3_s[1:0] == 2'd1 ? 3'd3 :
                        s3_s[1:0] == 2'd2 ? 3'd5 : 3'd7};
        setup2[`UPFC_SETUP2_FLDBK] <= ~s3_s[3];
        advert[1:0] <= (s3_s[1:0] == 2'd0) ? 2'd0 :
                       (s3_s[1:0] == 2'd3) ? 2'd2 : 2'd1;
      end
      if (strap_cnt != 2'd3) begin
        strap_cnt <= strap_cnt + 2'd1;
      end
      if (i_wr && i_addr == `UPFC_A_SETUP1) begin
        setup1 <= {3'h0, i_wdata[4:0]};
      end
      if (i_wr && i_addr == `UPFC_A_SETUP2) begin
        setup2 <= {4'h0, i_wdata[3:0]};
      end
      if (i_wr && i_addr == `UPFC_A_ADVERT) begin
        advert <= {6'h0, i_wdata[1:0]};
      end
      if (i_wr && i_addr == `UPFC_A_MASK1) begin
        mask1 <= i_wdata[1:0];
      end
      if (i_wr && i_addr == `UPFC_A_MASK2) begin
        mask2 <= i_wdata[1:0];
      end
      // a new event wins over a write-one clear in the same cycle
      irq1 <= (irq1 & ~(wr_irq1 ? i_wdata[1:0] : 2'h0)) | ev1;
      irq2 <= (irq2 & ~(wr_irq2 ? i_wdata[1:0] : 2'h0)) | ev2;
      if (i_rd) begin
        case (i_addr)
          `UPFC_A_SETUP1: o_rdata <= setup1;
          `UPFC_A_SETUP2: o_rdata <= setup2;
          `UPFC_A_ADVERT: o_rdata <= advert;
          `UPFC_A_IRQ1:   o_rdata <= {6'h0, irq1};
          `UPFC_A_IRQ2:   o_rdata <= {6'h0, irq2};
          `UPFC_A_MASK1:  o_rdata <= {6'h0, mask1};
          `UPFC_A_MASK2:  o_rdata <= {6'h0, mask2};
          `UPFC_A_STATUS: o_rdata <= {1'b0, o_switch_mode, warn_lvl,
                                      thermal_off, state, o_fault};
          default:        o_rdata <= 8'h00;
        endcase
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

  // ****************************************
  // outputs and data switch mode
  // ****************************************
  reg [1:0] next_mode;

  always @* begin
    if (!high_voltage_enable_s) begin
      next_mode = `UPFC_MODE_OFF;
    end else if (!supp_s) begin
      next_mode = `UPFC_MODE_BAD;
    end else if (cms_s || cds_s[0]) begin
      next_mode = `UPFC_MODE_CDP;
    end else if (cds_s == 2'b00) begin
      next_mode = `UPFC_MODE_SDP;
    end else begin
      next_mode = `UPFC_MODE_BAD;
    end
  end

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_converter_en           <= 1'b0;
      o_bus_output_gate        <= 1'b0;
      o_fault                  <= 1'b0;
      o_irq                    <= 1'b0;
      o_source_current         <= 2'h0;
      o_load_current_limit_sel <= 3'h0;
      o_cable_gain             <= 5'h00;
      o_data_switch_a          <= 1'b0;
      o_data_switch_b          <= 1'b0;
      o_switch_mode            <= `UPFC_MODE_OFF;
    end else if (i_ce) begin
      o_converter_en    <= (next_state == ST_RUN) && !thermal_off;
      o_bus_output_gate <= (next_state != ST_STB);
      o_fault           <= (next_state != ST_RUN);
      o_irq             <= |(irq1 & mask1) | |(irq2 & mask2);
      // foldback only steers the advert, never limit or mode
      o_source_current  <= (setup2[`UPFC_SETUP2_FLDBK] && warn_lvl) ?
                           upfc_fold(advert[1:0]) : advert[1:0];
      o_load_current_limit_sel <= setup2[2:0];
      o_cable_gain      <= setup1[4:0];
      o_switch_mode     <= next_mode;
      o_data_switch_a   <= (next_mode == `UPFC_MODE_SDP) ||
                           (next_mode == `UPFC_MODE_CDP && !cdp_s);
      o_data_switch_b   <= (next_mode == `UPFC_MODE_CDP) && cdp_s;
    end
  end
endmodule

/* File: bench/upfc_assertions.sv */
// port checker for the usb port protection and mode control block
// assumes i_ce stays high and undervolt stays low
`timescale 1ns/1ps
module upfc_assertions #(
  parameter STB_CYCLES = 50
) (
  input wire       i_core_clk,
  input wire       i_rst_n,
  input wire       i_rd,
  input wire [7:0] o_rdata,
  input wire       i_short_gnd,
  input wire       i_sense_neg_ov,
  input wire [7:0] i_die_temp,
  input wire       i_high_voltage_enable,
  input wire       i_logic_supply_sense,
  input wire       i_charge_mode_select,
  input wire [1:0] i_charge_detect_select,
  input wire       o_converter_en,
  input wire       o_bus_output_gate,
  input wire       o_fault,
  input wire [1:0] o_source_current,
  input wire [2:0] o_load_current_limit_sel,
  input wire       o_data_switch_a,
  input wire       o_data_switch_b,
  input wire [1:0] o_switch_mode
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // ****************************************
  // helpers
  // ****************************************
  logic [31:0] quiet;
  logic        hot;
  wire         en = i_high_voltage_enable && i_logic_supply_sense;
  // quiet saturates so a long run never wraps into a false stb window
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      quiet <= 32'hFFFF_FFFF;
      hot   <= 1'b0;
    end else begin
      if (i_sense_neg_ov)
        quiet <= 32'h0000_0000;
      else if (quiet != 32'hFFFF_FFFF)
        quiet <= quiet + 32'h0000_0001;
      if (i_die_temp > 8'd165)
        hot <= 1'b1;
      else if (i_die_temp <= 8'd155)
        hot <= 1'b0;
    end
  end
  sequence gnd_hit;
    $rose(i_short_gnd) && o_converter_en;
  endsequence
  sequence shut_s;
    o_fault && !o_converter_en;
  endsequence
  sequence gnd_gone;
    $fell(i_short_gnd) && !i_sense_neg_ov && !hot && quiet > STB_CYCLES + 8;
  endsequence
  // ****************************************
  // properties
  // ****************************************
  short_reset_a: assert property (gnd_hit |-> ##[1:4] shut_s)
    else $error("short did not reset converter");
  short_retry_a: assert property (gnd_gone |-> ##[1:60] o_converter_en)
    else $error("no retry after short");
  batt_gate_a: assert property ($rose(i_sense_neg_ov) && o_bus_output_gate
    |-> ##[1:4] (!o_bus_output_gate && o_fault))
    else $error("gate not opened on battery short");
  batt_hold_a: assert property ($rose(o_converter_en) |-> quiet >= STB_CYCLES)
    else $error("converter back before hold time");
  thermal_off_a: assert property (hot[*5] |-> !o_converter_en)
    else $error("converter on while hot");
  fold_only_a: assert property ($changed(o_source_current)
    && i_die_temp > 8'd100
    |-> $stable(o_load_current_limit_sel) && $stable(o_switch_mode))
    else $error("foldback touched limit or mode");
  sdp_mode_a: assert property ((en && !i_charge_mode_select
    && i_charge_detect_select == 2'h0)[*5]
    |-> o_switch_mode == 2'h1 && o_data_switch_a && !o_data_switch_b)
    else $error("sdp decode wrong");
  bad_mode_a: assert property ((i_high_voltage_enable
    && !i_logic_supply_sense)[*5] |-> o_switch_mode == 2'h3)
    else $error("missing supply not invalid");
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside slot");
endmodule
bind upfc_ctrl upfc_assertions #(.STB_CYCLES(STB_CYCLES)) chk_u (.*);

/* File: bench/upfc_port_model.sv */
// far side stand-in: portable device and upstream host transceiver
// assumes the bench asks for shorts and attach as levels
`timescale 1ns/1ps
module upfc_port_model (
  input  wire  i_core_clk,
  input  wire  i_plug_short,
  input  wire  i_harness_batt,
  input  wire  i_cdp_attach,
  output logic o_short_gnd,
  output logic o_sense_neg_ov,
  output logic o_cdp_status
);
  initial {o_short_gnd, o_sense_neg_ov, o_cdp_status} = 3'b000;
  // analog events land off the core edge, so the syncs see real skew
  always @(negedge i_core_clk) begin
    o_short_gnd    <= i_plug_short;
    o_sense_neg_ov <= i_harness_batt;
    o_cdp_status   <= i_cdp_attach;
  end
endmodule

/* File: bench/upfc_ctrl_bench.sv */
// self-checking bench for the port protection and mode control block
// assumes register variant, straps tied low, i_ce held high
`timescale 1ns/1ps
module upfc_ctrl_bench;
  logic       i_core_clk, i_rst_n, i_ce, i_wr, i_rd, i_undervolt;
  logic       i_short_gnd, i_sense_neg_ov, i_cdp_status, plug, batt, att;
  logic       i_high_voltage_enable, i_logic_supply_sense;
  logic       i_charge_mode_select, o_converter_en, o_bus_output_gate;
  logic       o_fault, o_irq, o_data_switch_a, o_data_switch_b;
  logic [1:0] i_charge_detect_select, o_source_current, o_switch_mode;
  logic [2:0] o_load_current_limit_sel;
  logic [3:0] i_addr, i_strap_pin_two, i_strap_pin_three;
  logic [4:0] o_cable_gain;
  logic [7:0] i_wdata, i_die_temp, o_rdata;
  int         err_count, checked, n;
  upfc_ctrl #(.STB_CYCLES(50), .RETRY_CYCLES(20)) dut_u (.*);
  upfc_port_model far_u (
    .i_core_clk     (i_core_clk),
    .i_plug_short   (plug),
    .i_harness_batt (batt),
    .i_cdp_attach   (att),
    .o_short_gnd    (i_short_gnd),
    .o_sense_neg_ov (i_sense_neg_ov),
    .o_cdp_status   (i_cdp_status)
  );
  // ****************************************
  // shared tasks
  // ****************************************
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task stop_test;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task lim;
    if (n >= 200) begin
      err_count++;
      stop_test;
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge i_core_clk);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_wr    <= 1'b0;
  endtask
  task rchk(input string s, input logic [3:0] a, input logic [7:0] e);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
    #1 chk(s, e, o_rdata);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    tick(5);
    chk("limit", 8'h03, o_load_current_limit_sel);
    chk("mode", 8'h05, {o_data_switch_b, o_data_switch_a, o_switch_mode});
    chk("conv", 8'h01, o_converter_en);
    rchk("setup1", 4'h0, 8'h00);
    rchk("setup2", 4'h1, 8'h0B);
    rchk("advert", 4'h2, 8'h01);
    rchk("irq1", 4'h3, 8'h00);
    rchk("unmapped", 4'h9, 8'h00);
  endtask
  task t_regs;
    wr(4'h0, 8'hF5);
    wr(4'h1, 8'h0F);
    wr(4'h2, 8'h02);
    tick(1);
    chk("gain", 8'h15, o_cable_gain);
    chk("limit", 8'h07, o_load_current_limit_sel);
    chk("source", 8'h02, o_source_current);
    rchk("setup1", 4'h0, 8'h15);
  endtask
  task t_short;
    wr(4'h5, 8'h03);
    plug <= 1'b1;
    for (n = 0; n < 200 && o_fault !== 1'b1; n++) tick(1);
    lim;
    chk("conv", 8'h00, o_converter_en);
    tick(2);
    chk("irq", 8'h01, o_irq);
    tick(40);
    plug <= 1'b0;
    for (n = 0; n < 200 && o_converter_en !== 1'b1; n++) tick(1);
    lim;
    chk("fault", 8'h00, o_fault);
    rchk("irq1", 4'h3, 8'h01);
    wr(4'h3, 8'h01);
    rchk("irq1", 4'h3, 8'h00);
    chk("irq", 8'h00, o_irq);
  endtask
  task t_batt;
    batt <= 1'b1;
    for (n = 0; n < 200 && o_bus_output_gate !== 1'b0; n++) tick(1);
    lim;
    chk("fault", 8'h01, o_fault);
    tick(10);
    batt <= 1'b0;
    for (n = 0; n < 200 && o_converter_en !== 1'b1; n++) tick(1);
    lim;
    chk("hold", 8'h01, n >= 50 && n < 60);
    chk("gate", 8'h01, o_bus_output_gate);
    rchk("irq1", 4'h3, 8'h02);
    wr(4'h3, 8'h02);
  endtask
  task t_therm;
    i_die_temp <= 8'd145;
    for (n = 0; n < 200 && o_source_current !== 2'h1; n++) tick(1);
    lim;
    chk("limit", 8'h07, o_load_current_limit_sel);
    chk("conv", 8'h01, o_converter_en);
    rchk("irq2", 4'h4, 8'h01);
    i_die_temp <= 8'd170;
    for (n = 0; n < 200 && o_converter_en !== 1'b0; n++) tick(1);
    lim;
    i_die_temp <= 8'd160;
    tick(20);
    chk("cool", 8'h00, o_converter_en);
    i_die_temp <= 8'd155;
    for (n = 0; n < 200 && o_converter_en !== 1'b1; n++) tick(1);
    lim;
    i_die_temp <= 8'd25;
    for (n = 0; n < 200 && o_source_current !== 2'h2; n++) tick(1);
    lim;
    rchk("irq2", 4'h4, 8'h03);
    wr(4'h4, 8'h03);
  endtask
  task t_modes;
    // {enable, supply, mode sel, detect sel, attach} -> {b, a, mode}
    logic [5:0] st [8] = '{6'h00, 6'h20, 6'h30, 6'h32, 6'h33,
                           6'h39, 6'h3C, 6'h34};
    logic [3:0] ex [8] = '{4'h0, 4'h3, 4'h5, 4'h6, 4'hA,
                           4'hA, 4'h6, 4'h3};
    for (int k = 0; k < 8; k++) begin
      {i_high_voltage_enable, i_logic_supply_sense, i_charge_mode_select,
       i_charge_detect_select, att} <= st[k];
      tick(6);
      chk("switch", {4'h0, ex[k]},
          {o_data_switch_b, o_data_switch_a, o_switch_mode});
    end
  endtask
  // ****************************************
  // clock, reset and sequence
  // ****************************************
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  initial begin
    #900000;
    err_count++;
    stop_test;
  end
  initial begin
    {i_wr, i_rd, i_undervolt, plug, batt, att, i_charge_mode_select} = '0;
    {i_rst_n, i_ce, i_high_voltage_enable, i_logic_supply_sense} = 4'hF;
    {i_addr, i_strap_pin_two, i_strap_pin_three} = 12'h000;
    {i_wdata, i_die_temp} = {8'h00, 8'd25};
    i_charge_detect_select = 2'h0;
    i_rst_n = 1'b0;
    repeat (4) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    t_reset;
    t_regs;
    t_short;
    t_batt;
    t_therm;
    t_modes;
    stop_test;
  end
endmodule
